//--- hdl/mcis_cfg.svh
// Offsets, field positions and timing counts of the instruction executor
`ifndef MCIS_CFG_SVH
`define MCIS_CFG_SVH
// APB register byte offsets
`define A_INSTR   8'h00
`define A_STATUS  8'h04
`define A_PC      8'h08
`define A_SP      8'h0C
`define A_PX      8'h10
`define A_PY      8'h14
`define A_PZ      8'h18
`define A_GPR     8'h1C
`define A_CTRL    8'h20
// Instruction word fields
`define F_OP_LSB  0
`define F_REG_LSB 5
`define F_BIT_LSB 10
`define F_PTR_LSB 13
`define F_IMM_LSB 16
// Status word bits above the status register byte
`define S_BUSY    8
`define S_HALT    9
`define S_IOERR   10
// Working register access word
`define G_IDX_LSB 8
`define G_WE      16
// Status register flag positions
`define FL_C      0
`define FL_Z      1
`define FL_N      2
`define FL_V      3
`define FL_S      4
`define FL_H      5
`define FL_T      6
`define FL_I      7
// Pointer selects
`define PTR_X     2'h0
`define PTR_Y     2'h1
// Low I/O window, reached at data address base plus index
`define IO_BASE   16'h0020
`define IO_MAX    16'h001F
// Instruction lengths in clock cycles
`define CYC_1     2'h1
`define CYC_2     2'h2
`define CYC_3     2'h3
`endif

//--- hdl/mcis_pkg.sv
// Types of the instruction executor
package mcis_pkg;
	typedef enum logic [4:0] {
		OP_NOP                   = 5'h00,
		OP_BRANCH_OVERFLOW_CLEAR = 5'h01,
		OP_BRANCH_IRQ_ENABLED    = 5'h02,
		OP_BRANCH_IRQ_DISABLED   = 5'h03,
		OP_ROTATE_LEFT_CARRY     = 5'h04,
		OP_ROTATE_RIGHT_CARRY    = 5'h05,
		OP_BIT_STORE_T           = 5'h06,
		OP_FLAG_SET              = 5'h07,
		OP_FLAG_CLR              = 5'h08,
		OP_SET_IO_BIT            = 5'h09,
		OP_CLEAR_IO_BIT          = 5'h0A,
		OP_LD_INC                = 5'h0B,
		OP_LD_DEC                = 5'h0C,
		OP_LOAD_DISPLACED        = 5'h0D,
		OP_ST_INC                = 5'h0E,
		OP_ST_DEC                = 5'h0F,
		OP_STORE_DISPLACED       = 5'h10,
		OP_LD_DIRECT             = 5'h11,
		OP_ST_DIRECT             = 5'h12,
		OP_PROGRAM_MEMORY_READ   = 5'h13,
		OP_PROGRAM_MEMORY_RD_INC = 5'h14,
		OP_PUSH                  = 5'h15,
		OP_POP                   = 5'h16,
		OP_BREAK                 = 5'h17
	} mcis_op_t;
	typedef enum logic [0:0] {
		FSM_IDLE = 1'b0,
		FSM_EXEC = 1'b1
	} mcis_fsm_t;
	typedef struct packed {
		mcis_fsm_t   fsm;
		logic [1:0]  cnt;
		logic [31:0] instr;
		logic [7:0]  status_register;
		logic [15:0] pc, sp, x, y, z;
		logic [15:0] dm_addr;
		logic        dm_re, dm_we;
		logic [7:0]  dm_wdata;
		logic [14:0] pm_addr;
		logic        pm_re;
		logic [31:0] prdata;
		logic        pready, pslverr;
		logic        halted, io_err, dbg_en;
		logic [4:0]  gpr_sel;
	} mcis_state_t;
endpackage

//--- hdl/mcis_rf_if.sv
// Working register file port between executor and storage
`timescale 1ns/1ns
interface mcis_rf_if;
	logic [4:0] raddr;
	logic [7:0] rdata;
	logic       we;
	logic [4:0] waddr;
	logic [7:0] wdata;
	modport core (output raddr, we, waddr, wdata, input rdata);
	modport mem  (input raddr, we, waddr, wdata, output rdata);
endinterface

//--- hdl/mcis_regfile.sv
// Thirty-two working registers with one write and one registered read port
`timescale 1ns/1ns
module mcis_regfile
	import mcis_pkg::*;
(
	input  wire logic clk_sys, // Core clock
	input  wire logic srst,    // Synchronous reset
	mcis_rf_if.mem    rf       // Register port
);
	logic [7:0] mem [32];

	// Write first-come; a read in the same cycle sees the old byte
	always_ff @(posedge clk_sys) begin
		if (rf.we) begin
			mem[rf.waddr] <= rf.wdata;
		end
	end

	// Registered read keeps the timing path short
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rf.rdata <= 8'h00;
		end else begin
			rf.rdata <= mem[rf.raddr];
		end
	end
endmodule

//--- hdl/mcis_core.sv
// Instruction subset executor with APB control and memory ports
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`include "mcis_cfg.svh"
module mcis_core
	import mcis_pkg::*;
(
	input  wire logic        clk_sys,  // Core clock, 100 MHz
	input  wire logic        srst,     // Synchronous reset, high
	input  wire logic        psel,     // APB select
	input  wire logic        penable,  // APB access phase
	input  wire logic        pwrite,   // APB direction
	input  wire logic [7:0]  paddr,    // APB byte address
	input  wire logic [31:0] pwdata,   // APB write data
	output logic      [31:0] prdata,   // APB read data
	output logic             pready,   // APB ready
	output logic             pslverr,  // APB error
	output logic      [15:0] dm_addr,  // Data memory address
	output logic             dm_re,    // Data memory read
	output logic             dm_we,    // Data memory write
	output logic      [7:0]  dm_wdata, // Data memory write byte
	input  wire logic [7:0]  dm_rdata, // Data memory read byte
	output logic      [14:0] pm_addr,  // Program memory word address
	output logic             pm_re,    // Program memory read
	input  wire logic [15:0] pm_rdata, // Program memory word
	output logic             busy      // Instruction in flight
);
	mcis_state_t s;
	mcis_state_t n;
	mcis_rf_if   rf ();
	logic [31:0] cur;
	mcis_op_t    op;
	logic [4:0]  rsel;
	logic [2:0]  bsel;
	logic [1:0]  ptr;
	logic [15:0] imm;
	logic [15:0] pval;
	logic [15:0] ea;
	logic [7:0]  fmask;
	logic        go;
	logic        e0;
	logic        run;
	logic        taken;
	logic        io_ok;
	logic [1:0]  cycles;
	logic        apb_wr;
	logic        wr_err;
	logic [7:0]  res;
	logic [7:0]  pbyte;

	mcis_regfile u_rf (
		.clk_sys (clk_sys),
		.srst    (srst),
		.rf      (rf.mem)
	);

	// Decode from the word being issued, else from the one in flight
	assign apb_wr = psel & penable & pwrite & s.pready;
	assign go     = apb_wr & ~s.pslverr & (paddr == `A_INSTR);
	assign run    = (s.fsm == FSM_EXEC);
	assign e0     = run & (s.cnt == 2'h0);
	assign cur    = go ? pwdata : s.instr;
	assign op     = mcis_op_t'(cur[`F_OP_LSB +: 5]);
	assign rsel   = cur[`F_REG_LSB +: 5];
	assign bsel   = cur[`F_BIT_LSB +: 3];
	assign ptr    = cur[`F_PTR_LSB +: 2];
	assign imm    = cur[`F_IMM_LSB +: 16];
	assign fmask  = 8'h01 << bsel;
	assign pbyte  = s.z[0] ? pm_rdata[15:8] : pm_rdata[7:0];
	assign io_ok  = (imm <= `IO_MAX);

	always_comb begin
		unique case (ptr)
			`PTR_X:  pval = s.x;
			`PTR_Y:  pval = s.y;
			default: pval = s.z;
		endcase
	end

	// Effective data address; pointers are still the old values here
	always_comb begin
		unique case (op)
			OP_LD_DEC, OP_ST_DEC:                 ea = pval - 16'h0001;
			OP_LOAD_DISPLACED, OP_STORE_DISPLACED: ea = pval + imm;
			OP_LD_DIRECT, OP_ST_DIRECT:          ea = imm;
			OP_PUSH:                             ea = s.sp;
			OP_POP:                              ea = s.sp + 16'h0001;
			OP_SET_IO_BIT, OP_CLEAR_IO_BIT:      ea = `IO_BASE + imm;
			default:                             ea = pval;
		endcase
	end

	always_comb begin
		unique case (op)
			OP_BRANCH_OVERFLOW_CLEAR: taken = ~s.status_register[`FL_V];
			OP_BRANCH_IRQ_ENABLED:    taken = s.status_register[`FL_I];
			OP_BRANCH_IRQ_DISABLED:   taken = ~s.status_register[`FL_I];
			default:                  taken = 1'b0;
		endcase
	end

	// Instruction length in cycles
	always_comb begin
		unique case (op)
			OP_BRANCH_OVERFLOW_CLEAR, OP_BRANCH_IRQ_ENABLED,
			OP_BRANCH_IRQ_DISABLED:
				cycles = taken ? `CYC_2 : `CYC_1;
			OP_SET_IO_BIT, OP_CLEAR_IO_BIT, OP_LD_INC, OP_LD_DEC,
			OP_LOAD_DISPLACED, OP_ST_INC, OP_ST_DEC,
			OP_STORE_DISPLACED, OP_LD_DIRECT, OP_ST_DIRECT,
			OP_PUSH, OP_POP:
				cycles = `CYC_2;
			OP_PROGRAM_MEMORY_READ, OP_PROGRAM_MEMORY_RD_INC:
				cycles = `CYC_3;
			default:
				cycles = `CYC_1;
		endcase
	end

	// Rotate result
	always_comb begin
		if (op == OP_ROTATE_RIGHT_CARRY) begin
			res = {s.status_register[`FL_C], rf.rdata[7:1]};
		end else begin
			res = {rf.rdata[6:0], s.status_register[`FL_C]};
		end
	end

	// Writes to A_INSTR, A_PC, A_SP, the pointers and A_GPR are refused while an instruction is in flight
	always_comb begin
		unique case (paddr)
			`A_INSTR:                   wr_err = run | s.halted;
			`A_PC, `A_SP, `A_PX, `A_PY,
			`A_PZ, `A_GPR:              wr_err = run;
			default:                    wr_err = 1'b0;
		endcase
	end

	// Next state of the whole block
	always_comb begin
		n          = s;
		n.dm_re    = 1'b0;
		n.dm_we    = 1'b0;
		n.pm_re    = 1'b0;
		n.pready   = 1'b0;
		n.pslverr  = 1'b0;
		rf.raddr   = (go | run) ? rsel : s.gpr_sel;
		rf.we      = 1'b0;
		rf.waddr   = rsel;
		rf.wdata   = 8'h00;
		// APB setup: answer in the next cycle
		if (psel & ~penable) begin
			n.pready = 1'b1;
			n.prdata = 32'h0000_0000;
			unique case (paddr)
				`A_INSTR:  n.prdata = s.instr;
				`A_STATUS: n.prdata = {21'h00_0000, s.io_err, s.halted,
					run, s.status_register};
				`A_PC:     n.prdata = {16'h0000, s.pc};
				`A_SP:     n.prdata = {16'h0000, s.sp};
				`A_PX:     n.prdata = {16'h0000, s.x};
				`A_PY:     n.prdata = {16'h0000, s.y};
				`A_PZ:     n.prdata = {16'h0000, s.z};
				`A_GPR:    n.prdata = {24'h00_0000, rf.rdata};
				`A_CTRL:   n.prdata = {31'h0000_0000, s.dbg_en};
				default:   n.pslverr = 1'b1;
			endcase
			if (pwrite & wr_err) begin
				n.pslverr = 1'b1;
			end
		end
		// APB access: writes land at the pready edge only
		if (apb_wr & ~s.pslverr) begin
			unique case (paddr)
				`A_STATUS: begin
					if (!run) begin
						n.status_register = pwdata[7:0];
					end
					if (pwdata[`S_HALT]) begin
						n.halted = 1'b0;
					end
					if (pwdata[`S_IOERR]) begin
						n.io_err = 1'b0;
					end
				end
				`A_PC:   n.pc = pwdata[15:0];
				`A_SP:   n.sp = pwdata[15:0];
				`A_PX:   n.x = pwdata[15:0];
				`A_PY:   n.y = pwdata[15:0];
				`A_PZ:   n.z = pwdata[15:0];
				`A_GPR: begin
					n.gpr_sel = pwdata[`G_IDX_LSB +: 5];
					rf.we     = pwdata[`G_WE];
					rf.waddr  = pwdata[`G_IDX_LSB +: 5];
					rf.wdata  = pwdata[7:0];
				end
				`A_CTRL: n.dbg_en = pwdata[0];
				default: ;
			endcase
		end
		// Issue: memory address goes out so data is back in cycle 0
		if (go) begin
			n.instr = pwdata;
			n.fsm   = FSM_EXEC;
			n.cnt   = 2'h0;
			n.dm_addr = ea;
			unique case (op)
				OP_SET_IO_BIT, OP_CLEAR_IO_BIT:
					n.dm_re = io_ok;
				OP_LD_INC, OP_LD_DEC, OP_LOAD_DISPLACED,
				OP_LD_DIRECT, OP_POP:
					n.dm_re = 1'b1;
				OP_PROGRAM_MEMORY_READ, OP_PROGRAM_MEMORY_RD_INC: begin
					n.pm_addr = s.z[15:1];
					n.pm_re   = 1'b1;
				end
				default: ;
			endcase
		end
		// Execute; the work is done in cycle 0, the rest is length
		if (run) begin
			n.cnt = s.cnt + 2'h1;
			if (s.cnt == cycles - 2'h1) begin
				n.fsm = FSM_IDLE;
			end
			if (s.cnt == 2'h0) begin
				unique case (op)
					OP_BRANCH_OVERFLOW_CLEAR, OP_BRANCH_IRQ_ENABLED,
					OP_BRANCH_IRQ_DISABLED: begin
						if (taken) begin
							n.pc = s.pc + imm + 16'h0001;
						end
					end
					OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY: begin
						rf.we    = 1'b1;
						rf.wdata = res;
						n.status_register[`FL_C] = (op == OP_ROTATE_LEFT_CARRY) ?
							rf.rdata[7] : rf.rdata[0];
						n.status_register[`FL_Z] = ~|res;
						n.status_register[`FL_N] = res[7];
						n.status_register[`FL_V] = res[7] ^ n.status_register[`FL_C];
					end
					OP_BIT_STORE_T: n.status_register[`FL_T] = rf.rdata[bsel];
					OP_FLAG_SET: n.status_register = s.status_register | fmask;
					OP_FLAG_CLR: n.status_register = s.status_register & ~fmask;
					OP_SET_IO_BIT, OP_CLEAR_IO_BIT: begin
						if (io_ok) begin
							n.dm_we    = 1'b1;
							n.dm_wdata = (op == OP_SET_IO_BIT) ?
								(dm_rdata | fmask) : (dm_rdata & ~fmask);
						end else begin
							n.io_err = 1'b1;
						end
					end
					OP_LD_INC, OP_LD_DEC, OP_LOAD_DISPLACED,
					OP_LD_DIRECT: begin
						rf.we    = 1'b1;
						rf.wdata = dm_rdata;
					end
					OP_ST_INC, OP_ST_DEC, OP_STORE_DISPLACED,
					OP_ST_DIRECT: begin
						n.dm_we    = 1'b1;
						n.dm_addr  = ea;
						n.dm_wdata = rf.rdata;
					end
					OP_PROGRAM_MEMORY_READ, OP_PROGRAM_MEMORY_RD_INC: begin
						rf.we    = 1'b1;
						rf.wdata = pbyte;
						if (op == OP_PROGRAM_MEMORY_RD_INC) begin
							n.z = s.z + 16'h0001;
						end
					end
					OP_PUSH: begin
						n.dm_we    = 1'b1;
						n.dm_addr  = ea;
						n.dm_wdata = rf.rdata;
						n.sp       = s.sp - 16'h0001;
					end
					OP_POP: begin
						rf.we    = 1'b1;
						rf.wdata = dm_rdata;
						n.sp     = s.sp + 16'h0001;
					end
					// Halt only under debug; a plain no-op otherwise
					OP_BREAK: n.halted = s.halted | s.dbg_en;
					default: ;
				endcase
				// Pointer update wraps at 16 bits
				if (op == OP_LD_INC || op == OP_ST_INC ||
					op == OP_LD_DEC || op == OP_ST_DEC) begin
					unique case (ptr)
						`PTR_X:  n.x = (op == OP_LD_INC || op == OP_ST_INC)
							? s.x + 16'h0001 : s.x - 16'h0001;
						`PTR_Y:  n.y = (op == OP_LD_INC || op == OP_ST_INC)
							? s.y + 16'h0001 : s.y - 16'h0001;
						default: n.z = (op == OP_LD_INC || op == OP_ST_INC)
							? s.z + 16'h0001 : s.z - 16'h0001;
					endcase
				end
			end
		end
	end

	// All core state in one register; reset clears it, but not the working register contents
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from the state register
	assign prdata   = s.prdata;
	assign pready   = s.pready;
	assign pslverr  = s.pslverr;
	assign dm_addr  = s.dm_addr;
	assign dm_re    = s.dm_re;
	assign dm_we    = s.dm_we;
	assign dm_wdata = s.dm_wdata;
	assign pm_addr  = s.pm_addr;
	assign pm_re    = s.pm_re;
	assign busy     = run;

	// Checks on instruction timing and effects
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	property p_branch_irq_enabled_len;
		go && op == OP_BRANCH_IRQ_ENABLED && s.status_register[`FL_I]
			|=> busy [*2] ##1 !busy;
	endproperty
	a_branch_irq_enabled_len: assert property (p_branch_irq_enabled_len)
		else $error("taken irq branch not two cycles");

	// An untaken branch still holds busy for its one cycle
	property p_branch_overflow_clear_nt;
		go && op == OP_BRANCH_OVERFLOW_CLEAR && s.status_register[`FL_V]
			|=> busy ##1 !busy && s.pc == $past(s.pc, 2);
	endproperty
	a_branch_overflow_clear_nt: assert property (p_branch_overflow_clear_nt)
		else $error("untaken overflow branch moved pc");

	property p_rotl;
		e0 && op == OP_ROTATE_LEFT_CARRY |=> s.status_register[`FL_C] ==
			$past(rf.rdata[7]) && s.status_register[`FL_N] == $past(rf.rdata[6]);
	endproperty
	a_rotl: assert property (p_rotl)
		else $error("rotate left flags wrong");

	property p_rotr;
		e0 && op == OP_ROTATE_RIGHT_CARRY |=> s.status_register[`FL_C] ==
			$past(rf.rdata[0]) && s.status_register[`FL_N] == $past(s.status_register[`FL_C]);
	endproperty
	a_rotr: assert property (p_rotr)
		else $error("rotate right flags wrong");

	property p_bst;
		e0 && op == OP_BIT_STORE_T |=> s.status_register[`FL_T] ==
			$past(rf.rdata[bsel]) && (s.status_register | 8'h40) ==
			($past(s.status_register) | 8'h40);
	endproperty
	a_bst: assert property (p_bst)
		else $error("bit store touched more than T");

	property p_fset;
		e0 && op == OP_FLAG_SET |=> s.status_register ==
			($past(s.status_register) | $past(fmask)) && !busy;
	endproperty
	a_fset: assert property (p_fset)
		else $error("flag set wrong");

	property p_hclr;
		e0 && op == OP_FLAG_CLR && bsel == 3'h5 |=> !s.status_register[`FL_H];
	endproperty
	a_hclr: assert property (p_hclr)
		else $error("half carry not cleared");

	property p_iobit;
		go && op == OP_SET_IO_BIT && io_ok |=> ##1 s.dm_we && busy &&
			s.dm_addr == `IO_BASE + $past(imm, 2) ##1 !busy;
	endproperty
	a_iobit: assert property (p_iobit)
		else $error("io bit write misplaced");

	property p_ldinc;
		go && op == OP_LD_INC && ptr == `PTR_X
			|=> ##1 s.x == $past(s.x, 2) + 16'h0001;
	endproperty
	a_ldinc: assert property (p_ldinc)
		else $error("post increment wrong");

	property p_lddec;
		go && op == OP_LD_DEC && ptr == `PTR_Y
			|=> s.dm_re && s.dm_addr == $past(s.y) - 16'h0001;
	endproperty
	a_lddec: assert property (p_lddec)
		else $error("pre decrement address wrong");

	property p_pmlen;
		go && op == OP_PROGRAM_MEMORY_READ |=> busy [*3] ##1 !busy;
	endproperty
	a_pmlen: assert property (p_pmlen)
		else $error("program read not three cycles");

	property p_push;
		go && op == OP_PUSH |=> ##1 s.dm_we && s.dm_addr == $past(s.sp, 2);
	endproperty
	a_push: assert property (p_push)
		else $error("push address wrong");

	property p_brk;
		go && op == OP_BREAK && !s.dbg_en |=> ##1 !s.halted;
	endproperty
	a_brk: assert property (p_brk)
		else $error("break halted without debug");

	property p_iorange;
		go && op == OP_SET_IO_BIT && !io_ok |=> !s.dm_we [*3];
	endproperty
	a_iorange: assert property (p_iorange)
		else $error("io bit op beyond low window");

	c_disp: cover property (go && op == OP_LOAD_DISPLACED);
	c_direct: cover property (go && op == OP_ST_DIRECT);
	c_halt: cover property (!s.halted ##1 s.halted);
endmodule

//--- test/mcis_mem_model.sv
// Data and program memory model on the far side of the executor
`timescale 1ns/1ns
module mcis_mem_model (
	input  wire logic        clk_sys,  // Core clock
	input  wire logic [15:0] dm_addr,  // Data address
	input  wire logic        dm_re,    // Data read strobe
	input  wire logic        dm_we,    // Data write strobe
	input  wire logic [7:0]  dm_wdata, // Data write byte
	output logic      [7:0]  dm_rdata, // Data read byte
	input  wire logic [14:0] pm_addr,  // Program word address
	input  wire logic        pm_re,    // Program read strobe
	output logic      [15:0] pm_rdata  // Program word
);
	logic [7:0]  dmem [65536];
	logic [15:0] pmem [32768];
	logic [7:0]  junk = 8'h00;

	// Writes land on the strobe edge; junk keeps idle lines moving
	always @(posedge clk_sys) begin
		junk <= junk + 8'h3B;
		if (dm_we)
			dmem[dm_addr] <= dm_wdata;
	end

	// Unselected reads show a changing pattern, so a late sample shows
	assign dm_rdata = dm_re ? dmem[dm_addr] : junk;
	assign pm_rdata = pm_re ? pmem[pm_addr] : {junk, ~junk};
endmodule

//--- test/mcis_core_tb.sv
// Self-checking bench for the instruction subset executor
`timescale 1ns/1ns
`include "mcis_cfg.svh"
module mcis_core_tb;
	import mcis_pkg::*;
	logic        clk_sys, srst, psel, penable, pwrite, pready, pslverr;
	logic        dm_re, dm_we, pm_re, busy, cy, tk;
	logic [7:0]  paddr, dm_wdata, dm_rdata, sr, v, w;
	logic [31:0] pwdata, prdata;
	logic [15:0] dm_addr, pm_rdata, p, k;
	logic [14:0] pm_addr;
	logic [2:0]  bt;
	logic [32:0] rd_q[$];
	logic [23:0] wr_q[$];
	int          n_mismatch, check_count, seed;

	mcis_core i_dut (.clk_sys(clk_sys), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dm_addr(dm_addr), .dm_re(dm_re),
		.dm_we(dm_we), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata),
		.pm_addr(pm_addr), .pm_re(pm_re), .pm_rdata(pm_rdata),
		.busy(busy));
	mcis_mem_model i_mem (.clk_sys(clk_sys), .dm_addr(dm_addr),
		.dm_re(dm_re), .dm_we(dm_we), .dm_wdata(dm_wdata),
		.dm_rdata(dm_rdata), .pm_addr(pm_addr), .pm_re(pm_re),
		.pm_rdata(pm_rdata));

	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		if (n_mismatch == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Clock and watchdog; the watchdog is far beyond the run length
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#300000;
		n_mismatch++;
		final_report();
	end

	// APB master: request held until pready is seen at an edge
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic e);
		int t;
		rd_q.push_back({e, d});
		@(posedge clk_sys);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge clk_sys);
			t++;
		end while (pready !== 1'b1 && t < 20);
		psel    <= 1'b0;
		penable <= 1'b0;
		check("pready", {31'h0, pready}, 32'h1);
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(1'b1, a, d, 1'b0);
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] d);
		apb(1'b0, a, d, 1'b0);
	endtask
	task automatic setg(logic [4:0] i, logic [7:0] d);
		wr(`A_GPR, {15'h0, 1'b1, 3'h0, i, d});
	endtask
	task automatic chkg(logic [4:0] i, logic [7:0] d);
		wr(`A_GPR, {19'h0, i, 8'h0});
		rd(`A_GPR, {24'h0, d});
	endtask

	// Issue one instruction and time its busy span
	task automatic ex(mcis_op_t o, logic [4:0] r, logic [2:0] b,
		logic [1:0] pt, logic [15:0] im, int n);
		int c;
		wr(`A_INSTR, {im, 1'b0, pt, b, r, o});
		c = 0;
		@(posedge clk_sys);
		while (busy === 1'b1 && c < 8) begin
			c++;
			@(posedge clk_sys);
		end
		check("cycles", c, n);
	endtask

	// One data memory transfer through a pointer, the stack or an address
	task automatic mem_op(logic st, mcis_op_t o, logic [1:0] pt,
		logic [7:0] pa, logic [15:0] pv, im, ea, np);
		logic [7:0] d;
		d = 8'($random(seed));
		if (st) begin
			setg(5'h7, d);
			wr_q.push_back({ea, d});
		end else
			i_mem.dmem[ea] = d;
		wr(pa, {16'h0, pv});
		ex(o, 5'h7, 3'h0, pt, im, 2);
		if (!st)
			chkg(5'h7, d);
		rd(pa, {16'h0, np});
	endtask

	// Replies and memory writes are matched against the oldest note
	always @(posedge clk_sys) begin
		logic [32:0] e;
		if (psel && penable && pready === 1'b1) begin
			e = rd_q.pop_front();
			check("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
			if (!pwrite)
				check("prdata", prdata, e[31:0]);
		end
		if (dm_we === 1'b1)
			check("dm_write", {8'h0, dm_addr, dm_wdata},
				{8'h0, wr_q.pop_front()});
	end

	initial begin
		seed = 32'hf0a2;
		srst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		n_mismatch = 0;
		check_count = 0;
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		for (int a = 4; a < 28; a += 4)
			rd(8'(a), 32'h0);
		apb(1'b0, 8'h24, 32'h0, 1'b1);
		// Every flag set then cleared alone
		sr = 8'h00;
		for (int i = 0; i < 16; i++) begin
			ex(i < 8 ? OP_FLAG_SET : OP_FLAG_CLR, 5'h0, 3'(i), 2'h0,
				16'h0, 1);
			sr[i % 8] = i < 8;
			rd(`A_STATUS, {24'h0, sr});
		end
		// Branch on V clear, I set and I clear, both outcomes
		for (int o = 1; o < 4; o++)
			for (int s = 0; s < 2; s++) begin
				p = 16'($random(seed));
				k = 16'($random(seed));
				sr = s ? 8'h88 : 8'h00;
				wr(`A_STATUS, {24'h0, sr});
				wr(`A_PC, {16'h0, p});
				tk = (o == 2) ? s[0] : !s[0];
				ex(mcis_op_t'(o[4:0]), 5'h0, 3'h0, 2'h0, k, tk ? 2 : 1);
				rd(`A_PC, {16'h0, tk ? p + k + 16'h1 : p});
				rd(`A_STATUS, {24'h0, sr});
			end
		// Rotates with zero results first, then bit store to T
		for (int i = 0; i < 8; i++) begin
			v = 8'($random(seed));
			sr = 8'($random(seed));
			if (i < 2) begin
				v = i ? 8'h01 : 8'h80;
				sr[0] = 1'b0;
			end
			setg(5'h3, v);
			wr(`A_STATUS, {24'h0, sr});
			w = i[0] ? {sr[0], v[7:1]} : {v[6:0], sr[0]};
			cy = i[0] ? v[0] : v[7];
			ex(i[0] ? OP_ROTATE_RIGHT_CARRY : OP_ROTATE_LEFT_CARRY, 5'h3,
				3'h0, 2'h0, 16'h0, 1);
			sr[3:0] = {w[7] ^ cy, w[7], w == 8'h00, cy};
			chkg(5'h3, w);
			rd(`A_STATUS, {24'h0, sr});
			ex(OP_BIT_STORE_T, 5'h3, 3'(i), 2'h0, 16'h0, 1);
			sr[6] = w[i];
			rd(`A_STATUS, {24'h0, sr});
		end
		// Read-modify-write of a low I/O register, then out of range
		for (int i = 0; i < 2; i++) begin
			v = 8'($random(seed));
			bt = 3'($random(seed));
			i_mem.dmem[`IO_BASE + 16'h5] = v;
			w = i ? v & ~(8'h1 << bt) : v | (8'h1 << bt);
			wr_q.push_back({`IO_BASE + 16'h5, w});
			ex(i ? OP_CLEAR_IO_BIT : OP_SET_IO_BIT, 5'h0, bt, 2'h0,
				16'h5, 2);
		end
		ex(OP_SET_IO_BIT, 5'h0, 3'h0, 2'h0, 16'h20, 2);
		rd(`A_STATUS, {21'h0, 3'h4, sr});
		wr(`A_STATUS, {21'h0, 3'h4, sr});
		rd(`A_STATUS, {24'h0, sr});
		// Pointer modes, wrap at both ends, direct and stack
		mem_op(1'b0, OP_LD_INC, 2'h0, `A_PX, 16'hFFFF, 16'h0, 16'hFFFF,
			16'h0);
		mem_op(1'b0, OP_LD_DEC, 2'h1, `A_PY, 16'h0, 16'h0, 16'hFFFF,
			16'hFFFF);
		mem_op(1'b0, OP_LOAD_DISPLACED, 2'h2, `A_PZ, 16'h1234, 16'h10,
			16'h1244, 16'h1234);
		mem_op(1'b0, OP_LOAD_DISPLACED, 2'h1, `A_PY, 16'h300, 16'h3F,
			16'h33F, 16'h300);
		mem_op(1'b0, OP_LD_DIRECT, 2'h0, `A_PX, 16'h100, 16'h456,
			16'h456, 16'h100);
		mem_op(1'b1, OP_ST_INC, 2'h2, `A_PZ, 16'h200, 16'h0, 16'h200,
			16'h201);
		mem_op(1'b1, OP_ST_DEC, 2'h0, `A_PX, 16'h300, 16'h0, 16'h2FF,
			16'h2FF);
		mem_op(1'b1, OP_STORE_DISPLACED, 2'h1, `A_PY, 16'h400, 16'h5,
			16'h405, 16'h400);
		mem_op(1'b1, OP_ST_DIRECT, 2'h0, `A_PX, 16'h10, 16'h777,
			16'h777, 16'h10);
		mem_op(1'b1, OP_PUSH, 2'h0, `A_SP, 16'h100, 16'h0, 16'h100,
			16'hFF);
		mem_op(1'b0, OP_POP, 2'h0, `A_SP, 16'hFF, 16'h0, 16'h100,
			16'h100);
		rd(`A_STATUS, {24'h0, sr});
		// Program memory byte at Z, both byte lanes, with and without bump
		for (int i = 0; i < 2; i++) begin
			p = {15'($random(seed)), i[0]};
			k = 16'($random(seed));
			i_mem.pmem[p[15:1]] = k;
			wr(`A_PZ, {16'h0, p});
			ex(i ? OP_PROGRAM_MEMORY_RD_INC : OP_PROGRAM_MEMORY_READ, 5'h9,
				3'h0, 2'h2, 16'h0, 3);
			chkg(5'h9, p[0] ? k[15:8] : k[7:0]);
			rd(`A_PZ, {16'h0, i ? p + 16'h1 : p});
		end
		// A new instruction during a long one is refused
		wr(`A_INSTR, {27'h0, OP_PROGRAM_MEMORY_READ});
		apb(1'b1, `A_INSTR, 32'h0, 1'b1);
		// Break is a no-op unless debugging is enabled
		ex(OP_BREAK, 5'h0, 3'h0, 2'h0, 16'h0, 1);
		rd(`A_STATUS, {24'h0, sr});
		wr(`A_CTRL, 32'h1);
		ex(OP_BREAK, 5'h0, 3'h0, 2'h0, 16'h0, 1);
		rd(`A_STATUS, {22'h0, 2'h2, sr});
		apb(1'b1, `A_INSTR, 32'h0, 1'b1);
		wr(`A_STATUS, {22'h0, 2'h2, sr});
		rd(`A_STATUS, {24'h0, sr});
		repeat (4) @(posedge clk_sys);
		final_report();
	end
endmodule
